// ---- sdil_params.svh ----
`ifndef SDIL_PARAMS_SVH
`define SDIL_PARAMS_SVH

`define SDIL_WORD_BITS 16
`define SDIL_SEG_BITS 4
`define SDIL_LADDER_BITS 12
`define SDIL_SEG_COUNT 15
`define SDIL_MID_CODE 16'h8000
`define SDIL_SYNC_STAGES 2

`endif

// ---- sdil_pkg.sv ----
package sdil_pkg;
  // serial pins as sampled on the device side
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } sdil_link_t;

  // what the analog core sees
  typedef struct packed {
    logic [14:0] seg;
    logic [11:0] ladder;
  } sdil_switch_t;

  typedef enum logic [0:0] {
    SDIL_IDLE,
    SDIL_FRAME
  } sdil_state_t;
endpackage

// ---- sdil_seg_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sdil_params.svh"

// thermometer decoder for the segment bank
module sdil_seg_decode
  import sdil_pkg::*;
#(
  parameter int SEG_BITS = `SDIL_SEG_BITS,
  parameter int SEG_COUNT = `SDIL_SEG_COUNT
) (
  input wire logic [SEG_BITS-1:0] upper,
  output logic [SEG_COUNT-1:0] therm
);

  // bit k-1 is segment k; on when upper >= k
  genvar k;
  generate
    for (k = 1; k <= SEG_COUNT; k++) begin : g_seg
      assign therm[k-1] = (32'(upper) >= k);
    end
  endgenerate

endmodule
`default_nettype wire

// ---- sdil_serial_dac.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sdil_params.svh"

// How it works
// - din is sampled into the shift register on each serial clock rising edge.
// - data is accepted only while chip select is low.
// - while the load strobe is low the code register follows the input register.
// - reset puts the code register at mid-scale.
// - a frame carries one 16-bit word.
// - the upper four code bits drive the fifteen segment switches.
// - the lower twelve code bits drive ladder switches zero to eleven.
// - words arrive most significant bit first.
// - at chip select rising, the word loads to code if the strobe is low.
// - serial clock and data are ignored while chip select is high.
// - a new input word leaves the code untouched until the strobe transfers it.
module sdil_serial_dac
  import sdil_pkg::*;
#(
  parameter int WORD_BITS = `SDIL_WORD_BITS
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic load_code_strobe_n,
  output logic [14:0] segment_switch_controls,
  output logic [11:0] ladder_switch_controls,
  output logic [WORD_BITS-1:0] code_word,
  output logic [WORD_BITS-1:0] input_word,
  output logic frame_active
);

  // every pin is brought into the mclk domain before use; the serial clock
  // is treated as data, so its edges are found by comparing synchronised
  // samples. this costs three mclk edges of latency per bit but keeps the
  // whole block on one clock with no pin-driven flops.

  // two-stage synchronisers; stage one feeds stage two only
  // reset levels match idle pins: chip select and strobe high, sclk low,
  // so the edge detectors see no false rise when reset lets go
  // the bit order is {cs_n, sclk, din, strobe}
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sync1_r <= 4'hB;
      sync2_r <= 4'hB;
    end else begin
      sync1_r <= {cs_n, sclk, din, load_code_strobe_n};
      sync2_r <= sync1_r;
    end
  end

  sdil_link_t link;
  wire ld_n_s;
  assign link = sdil_link_t'(sync2_r[3:1]);
  assign ld_n_s = sync2_r[0];

  // previous sampled levels for edge detection
  // reset values equal the synchronisers' reset levels
  logic sclk_d_r;
  logic cs_d_r;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sclk_d_r <= link.sclk;
      cs_d_r <= link.cs_n;
    end
  end

  // rising-edge test shared by the serial clock and chip select detectors
  function automatic logic rise_of(input logic now_lvl, input logic was_lvl);
    return now_lvl & ~was_lvl;
  endfunction

  wire sclk_rise;
  wire cs_rise;
  wire shift_en;
  assign sclk_rise = rise_of(link.sclk, sclk_d_r);
  assign cs_rise = rise_of(link.cs_n, cs_d_r);
  assign shift_en = sclk_rise & ~link.cs_n;

  // frame state, just for visibility of an open frame
  // the default branch returns to idle should the state ever be corrupted
  sdil_state_t state_r;
  sdil_state_t state_nxt;
  always_comb begin
    case (state_r)
      SDIL_IDLE: state_nxt = link.cs_n ? SDIL_IDLE : SDIL_FRAME;
      SDIL_FRAME: state_nxt = link.cs_n ? SDIL_IDLE : SDIL_FRAME;
      default: state_nxt = SDIL_IDLE;
    endcase
  end
  // frame_active is for visibility only; nothing else reads it
  assign frame_active = (state_r == SDIL_FRAME);

  // input shift register; the last 16 bits shifted win, msb first
  // bits beyond sixteen push older ones out; a short frame leaves older bits shifted into the upper positions
  logic [WORD_BITS-1:0] shift_r;
  logic [WORD_BITS-1:0] shift_nxt;
  assign shift_nxt = shift_en ? {shift_r[WORD_BITS-2:0], link.din} : shift_r;

  // code register: level transfer while strobe low, or at cs rise with strobe low
  // cs rise and strobe-low transfer copy the same word, so they never disagree
  // the strobe is a level: held low mid-frame, the code tracks each shifted bit
  logic [WORD_BITS-1:0] code_r;
  wire load_now;
  assign load_now = ~ld_n_s | (cs_rise & ~ld_n_s);

  // frame flag register; lags the synchronised chip select by one edge
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_r <= SDIL_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // input shift register; shift_nxt already holds it outside accepted edges
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      shift_r <= '0;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // code register; only the strobe path writes it, so pre-loading is safe
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      code_r <= WORD_BITS'(`SDIL_MID_CODE);
    end else if (load_now) begin
      code_r <= shift_r;
    end
  end

  // visibility ports and the ladder bank come straight from registers
  assign code_word = code_r;
  assign input_word = shift_r;
  assign ladder_switch_controls = code_r[`SDIL_LADDER_BITS-1:0];

  // the segment decoder is a separate module so it can be checked alone
  // its input is the top four code bits
  sdil_seg_decode #(
    .SEG_BITS(`SDIL_SEG_BITS),
    .SEG_COUNT(`SDIL_SEG_COUNT)
  ) u_seg (
    .upper(code_r[WORD_BITS-1 -: `SDIL_SEG_BITS]),
    .therm(segment_switch_controls)
  );

  // checks
  // pin to register latency is two synchroniser edges plus one register edge;
  // a pin level held for fewer than two mclk cycles may be missed entirely,
  // so the serial clock must stay well under a quarter of mclk

  // reset values
  a_reset_mid_code: assert property (@(posedge mclk) $rose(rstn) |-> code_r == 16'h8000)
    else $error("code not mid-scale after reset");
  a_reset_outputs: assert property (@(posedge mclk)
    $rose(rstn) |-> !frame_active && input_word == 16'h0000 && ladder_switch_controls == 12'h000)
    else $error("outputs not at reset values");

  // input shift register
  a_idle_no_shift: assert property (@(posedge mclk) disable iff (!rstn)
    link.cs_n |=> $stable(shift_r))
    else $error("input register moved with chip select high");
  a_no_edge_hold: assert property (@(posedge mclk) disable iff (!rstn)
    !shift_en |=> $stable(shift_r))
    else $error("input register moved without an accepted edge");
  a_shift_msb_first: assert property (@(posedge mclk) disable iff (!rstn)
    shift_en |=> shift_r == {$past(shift_r[14:0]), $past(link.din)})
    else $error("shift order wrong");
  a_pin_latency: assert property (@(posedge mclk) disable iff (!rstn)
    (!cs_n && $rose(sclk)) ##1 (!cs_n && sclk) ##1 (!cs_n && sclk)
    |=> $changed(shift_r) || $past(shift_r[14:0]) == shift_r[15:1])
    else $error("accepted edge not shifted");

  // synchroniser and frame flag timing
  a_sync_delay: assert property (@(posedge mclk) disable iff (!rstn)
    {link.cs_n, link.sclk, ld_n_s} == $past({cs_n, sclk, load_code_strobe_n}, 2))
    else $error("pin synchroniser delay wrong");
  a_frame_flag: assert property (@(posedge mclk) disable iff (!rstn)
    1'b1 |=> frame_active == !$past(link.cs_n))
    else $error("frame flag out of step with chip select");

  // code register
  a_code_holds: assert property (@(posedge mclk) disable iff (!rstn)
    ld_n_s |=> $stable(code_r))
    else $error("code changed without strobe");
  a_strobe_loads: assert property (@(posedge mclk) disable iff (!rstn)
    !ld_n_s |=> code_r == $past(shift_r))
    else $error("strobe did not transfer word");
  a_cs_rise_load: assert property (@(posedge mclk) disable iff (!rstn)
    (cs_rise && !ld_n_s) |=> code_r == $past(shift_r))
    else $error("cs rise with strobe low did not load");

  // switch banks
  a_ladder_map: assert property (@(posedge mclk) disable iff (!rstn)
    ladder_switch_controls == code_r[11:0])
    else $error("ladder bits wrong");
  a_seg_therm: assert property (@(posedge mclk) disable iff (!rstn)
    $countones(segment_switch_controls) == code_r[15:12]
    && (segment_switch_controls & (segment_switch_controls + 15'h0001)) == 15'h0000)
    else $error("segment decode wrong");
  a_seg_top: assert property (@(posedge mclk) disable iff (!rstn)
    segment_switch_controls[14] == (code_r[15:12] == 4'hF))
    else $error("top segment wrong");

  // main scenarios: whole frame, load at chip select rise, pre-load, full scale, ignored clock
  c_frame: cover property (@(posedge mclk) $fell(link.cs_n) ##[1:1000] cs_rise);
  c_load_at_cs: cover property (@(posedge mclk) cs_rise && !ld_n_s);
  c_preload: cover property (@(posedge mclk) cs_rise && ld_n_s);
  c_full_scale: cover property (@(posedge mclk) segment_switch_controls == 15'h7FFF);
  c_ignored_clock: cover property (@(posedge mclk) sclk_rise && link.cs_n);

endmodule
`default_nettype wire

// ---- sdil_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// host serial port; sclk idles low between frames
module sdil_host_model (
  input wire logic mclk,
  output logic cs_n,
  output logic sclk,
  output logic din
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // half of a 160 ns sclk period
  task automatic half();
    repeat (16) @(posedge mclk);
  endtask
  // sel low sends the clocks with chip select held high
  task automatic send(input logic [15:0] w, input logic sel);
    cs_n <= ~sel;
    for (int i = 15; i >= 0; i--) begin
      din <= w[i]; // stable across the rise
      half();
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
    half();
    cs_n <= 1'b1;
    din <= ~din; // a released line must not keep its value
    half();
  endtask
endmodule
`default_nettype wire

// ---- test_serial_dac_input_logic.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_serial_dac_input_logic;
  import sdil_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic load_code_strobe_n = 1'b1;
  wire logic cs_n, sclk, din;
  logic [14:0] seg;
  logic [11:0] lad;
  logic fa;
  logic [15:0] code, inw, e, w;
  logic [15:0] prev = 16'h8000;
  logic [15:0] exp_q[$];
  int mismatches = 0;
  int total_checks = 0;
  always #2.5 mclk = ~mclk;
  sdil_host_model u_host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .din(din));
  sdil_serial_dac u_dut (.mclk(mclk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .din(din),
    .load_code_strobe_n(load_code_strobe_n), .segment_switch_controls(seg),
    .ladder_switch_controls(lad), .code_word(code), .input_word(inw), .frame_active(fa));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // u segments on, thermometer style
  function automatic logic [15:0] therm(input logic [3:0] u);
    return (16'h0001 << u) - 16'h0001;
  endfunction
  // any move of the code without a note compares against the old code
  always @(posedge mclk) begin
    if (rstn && code !== prev) begin
      e = exp_q.size() ? exp_q.pop_front() : prev;
      chk(code, e);
      chk({1'b0, seg}, therm(e[15:12]));
      chk({4'h0, lad}, {4'h0, e[11:0]});
      prev = code;
    end
  end
  // bounded wait for the monitor to use up the notes
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (exp_q.size() > 0) begin
      mismatches++;
      test_done();
    end
  endtask
  initial begin
    void'($urandom(32'h87A9));
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    chk(code, 16'h8000);
    chk({1'b0, seg}, 16'h00FF);
    $display("reset test done");
    // every upper field value once, random ladder bits
    for (int k = 0; k < 16; k++) begin
      w = {k[3:0], 12'($urandom)};
      u_host.send(w, 1'b1);
      chk(inw, w);
      chk({15'h0000, fa}, 16'h0000);
      u_host.send(~w, 1'b0);
      chk(inw, w);
      exp_q.push_back(w);
      load_code_strobe_n <= 1'b0;
      drain();
      load_code_strobe_n <= 1'b1;
      @(posedge mclk);
      $display("frame test %0d done", k);
    end
    // strobe falls after the last bit while chip select is still low
    w = {4'h5, 12'($urandom)};
    exp_q.push_back(w);
    fork
      u_host.send(w, 1'b1);
      begin
        repeat (100) @(posedge mclk);
        chk({15'h0000, fa}, 16'h0001);
        repeat (420) @(posedge mclk);
        load_code_strobe_n <= 1'b0;
      end
    join
    drain();
    chk(inw, w);
    load_code_strobe_n <= 1'b1;
    @(posedge mclk);
    $display("load at chip select test done");
    test_done();
  end
endmodule
`default_nettype wire
